// File: pkg/blp_pkg.sv
package blp_pkg;
    // Interval lengths in ns; cycle counts derived at 100 ns per clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int LEB_NS = 300;
    localparam int TON_MAX_NS = 25000;
    localparam int TOFF_MAX_NS = 20000;
    localparam int SC_DET_NS = 5000000;
    // Least time rounds up
    localparam int LEB_CYC = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest times round down
    localparam int TON_CYC = TON_MAX_NS / CLK_PERIOD_NS;
    localparam int TOFF_CYC = TOFF_MAX_NS / CLK_PERIOD_NS;
    localparam int SC_CYC = SC_DET_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam int SC_W = 24;

    typedef enum logic [2:0] {
        BLP_OFF = 3'h0,
        BLP_PRIME = 3'h1,
        BLP_ON = 3'h2,
        BLP_STROKE = 3'h3,
        BLP_HALT = 3'h4,
        BLP_LATCH = 3'h5
    } blp_state_e;

    // Analog comparator flags from the pins
    typedef struct packed {
        logic supply_start_level;
        logic supply_stop_level;
        logic supply_reset_level;
        logic backup_regulator_on_level;
        logic sense_trip_level;
        logic sense_short_level;
        logic coil_zero;
        logic valley;
        logic valley_in_range;
        logic overtemp_activate_level;
        logic overtemp_release_level;
        logic led_overtemp;
    } blp_cmp_s;

    typedef struct packed {
        logic shorted_coil_trip;
        logic output_short_trip;
        logic overtemp_trip;
        logic led_overtemp_trip;
    } blp_fault_s;
endpackage

// File: verilog/blp_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// (RULE_01) Each cycle turns the switch on; peak-current trip turns it off.
// (RULE_02) After coil current is zero, next cycle starts at a drain valley.
// (RULE_03) Valley counts only when ringing frequency and swing are in range.
// (RULE_04) Without valid valley, switch stays off until maximum off-time.
// (RULE_05) Shorted-coil and output-short faults latch until supply reset level.
// (RULE_06) Over-temperature faults halt, let supply fall, then restart.
// (RULE_07) Switching begins only when no fault condition is present.
// (RULE_08) Below stop level, stop switching and recharge from start-up source.
// (RULE_09) Sense comparators are ignored during blanking after turn-on.
// (RULE_10) Overcurrent trip acts only after blanking and ends the on stroke.
// (RULE_11) Die overtemp halts until temperature falls below release level.
// (RULE_12) Maximum on-time ends the on stroke without peak current.
// (RULE_13) Sense above 1.5 V after blanking trips latched shorted-coil fault.
// (RULE_14) Off stroke ended by maximum off-time starts short-detect timer.
// (RULE_15) Valid valley or supply below stop level clears short timer.
// (RULE_16) Cycle ended by maximum on-time clears short timer.
// (RULE_17) Short timer expiry trips latched output-short fault.
// (RULE_18) Start above start level, stop below stop level, with hysteresis.
// (RULE_19) Start-up source supplies device until other supply takes over.
// (RULE_20) Backup regulator on below its level, off above it.
// (RULE_21) Comparators synchronised; all intervals are cycle counters.
module blp_ctrl #(
    parameter int LEB_CYCLES = blp_pkg::LEB_CYC,
    parameter int TON_CYCLES = blp_pkg::TON_CYC,
    parameter int TOFF_CYCLES = blp_pkg::TOFF_CYC,
    parameter int SC_CYCLES = blp_pkg::SC_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire blp_pkg::blp_cmp_s cmp_in,
    output logic switch_on,
    output logic startup_source_on,
    output logic backup_regulator_on,
    output blp_pkg::blp_fault_s fault,
    output logic running
);
    localparam int CW = blp_pkg::CNT_W;
    localparam int SW = blp_pkg::SC_W;
    localparam int NC = $bits(blp_pkg::blp_cmp_s);

    // Three-stage synchroniser; changes accepted when stages 2 and 3 agree
    logic [NC-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
    logic [NC-1:0] s1_next, s2_next, s3_next, flt_next;
    blp_pkg::blp_cmp_s c;

    always_comb begin
        s1_next = cmp_in;
        s2_next = s1_reg;
        s3_next = s2_reg;
        flt_next = flt_reg;
        for (int i = 0; i < NC; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                flt_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            flt_reg <= '0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            flt_reg <= flt_next;
        end
    end

    assign c = flt_reg; // see (RULE_21)

    blp_pkg::blp_state_e state_reg, state_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [SW-1:0] sc_reg, sc_next;
    logic sc_run_reg, sc_run_next;
    blp_pkg::blp_fault_s flt_q_reg, flt_q_next;
    logic regon_reg, regon_next;
    logic blanked, ton_hit, toff_hit, valley_ok, any_fault;

    assign blanked = cnt_reg < CW'(LEB_CYCLES); // see (RULE_09)
    assign ton_hit = cnt_reg >= CW'(TON_CYCLES - 1); // see (RULE_12)
    assign toff_hit = cnt_reg >= CW'(TOFF_CYCLES - 1); // see (RULE_04)
    // Valley only honoured once coil current has reached zero
    assign valley_ok = c.coil_zero && c.valley
        && c.valley_in_range; // see (RULE_02) see (RULE_03)
    assign any_fault = |flt_q_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sc_next = sc_reg;
        sc_run_next = sc_run_reg;
        flt_q_next = flt_q_reg;
        regon_next = regon_reg;
        // Regulator level has its own hysteresis in the analog comparator
        regon_next = c.backup_regulator_on_level; // see (RULE_20)
        if (sc_run_reg) begin
            sc_next = sc_reg + SW'(1);
        end
        if (c.overtemp_activate_level) begin
            flt_q_next.overtemp_trip = 1'b1; // see (RULE_11)
        end
        if (c.led_overtemp) begin
            flt_q_next.led_overtemp_trip = 1'b1; // see (RULE_06)
        end
        case (state_reg)
            blp_pkg::BLP_OFF: begin
                cnt_next = '0;
                // Die overtemp clears only below release threshold
                if (c.overtemp_release_level) begin
                    flt_q_next.overtemp_trip = 1'b0; // see (RULE_11)
                end
                if (!c.led_overtemp) begin
                    flt_q_next.led_overtemp_trip = 1'b0;
                end
                if (c.supply_start_level && !any_fault) begin
                    state_next = blp_pkg::BLP_ON; // see (RULE_07) see (RULE_18)
                end
            end
            blp_pkg::BLP_ON: begin
                cnt_next = cnt_reg + CW'(1); // see (RULE_01)
                if (!blanked && c.sense_short_level) begin
                    flt_q_next.shorted_coil_trip = 1'b1; // see (RULE_13)
                    state_next = blp_pkg::BLP_LATCH; // see (RULE_05)
                end else if (!blanked && c.sense_trip_level) begin
                    state_next = blp_pkg::BLP_STROKE; // see (RULE_10)
                    cnt_next = '0;
                end else if (ton_hit) begin
                    state_next = blp_pkg::BLP_STROKE; // see (RULE_12)
                    cnt_next = '0;
                    sc_run_next = 1'b0; // see (RULE_16)
                    sc_next = '0;
                end
            end
            blp_pkg::BLP_STROKE: begin
                cnt_next = cnt_reg + CW'(1);
                if (valley_ok) begin
                    state_next = blp_pkg::BLP_ON; // see (RULE_02)
                    cnt_next = '0;
                    sc_run_next = 1'b0; // see (RULE_15)
                    sc_next = '0;
                end else if (toff_hit) begin
                    state_next = blp_pkg::BLP_ON; // see (RULE_04)
                    cnt_next = '0;
                    sc_run_next = 1'b1; // see (RULE_14)
                end
            end
            blp_pkg::BLP_LATCH: begin
                cnt_next = '0;
                if (c.supply_reset_level) begin
                    flt_q_next.shorted_coil_trip = 1'b0; // see (RULE_05)
                    flt_q_next.output_short_trip = 1'b0;
                    state_next = blp_pkg::BLP_OFF;
                end
            end
            default: begin
                state_next = blp_pkg::BLP_OFF;
                cnt_next = '0;
            end
        endcase
        // Expiry checked after the case so a stroke change cannot undo it
        if (sc_run_reg && sc_reg >= SW'(SC_CYCLES - 1)) begin
            flt_q_next.output_short_trip = 1'b1; // see (RULE_17)
            sc_run_next = 1'b0;
            sc_next = '0;
            state_next = blp_pkg::BLP_LATCH;
        end
        // Temperature faults halt and restart; a latch must never be lost
        if ((state_reg == blp_pkg::BLP_ON || state_reg == blp_pkg::BLP_STROKE)
            && state_next != blp_pkg::BLP_LATCH
            && (flt_q_next.overtemp_trip
            || flt_q_next.led_overtemp_trip)) begin
            state_next = blp_pkg::BLP_OFF; // see (RULE_06)
            cnt_next = '0;
        end
        // Undervoltage overrides all except a held or newly entered latch
        if (c.supply_stop_level && state_reg != blp_pkg::BLP_LATCH
            && state_next != blp_pkg::BLP_LATCH) begin
            state_next = blp_pkg::BLP_OFF; // see (RULE_08) see (RULE_18)
            cnt_next = '0;
        end
        if (c.supply_stop_level) begin
            sc_run_next = 1'b0; // see (RULE_15)
            sc_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= blp_pkg::BLP_OFF;
            cnt_reg <= '0;
            sc_reg <= '0;
            sc_run_reg <= 1'b0;
            flt_q_reg <= '0;
            regon_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sc_reg <= sc_next;
            sc_run_reg <= sc_run_next;
            flt_q_reg <= flt_q_next;
            regon_reg <= regon_next;
        end
    end

    assign switch_on = state_reg == blp_pkg::BLP_ON;
    // Start-up source recharges supply only in the off state, not in the latch
    assign startup_source_on = state_reg == blp_pkg::BLP_OFF; // see (RULE_19)
    assign backup_regulator_on = regon_reg;
    assign fault = flt_q_reg;
    assign running = state_reg == blp_pkg::BLP_ON
        || state_reg == blp_pkg::BLP_STROKE;
endmodule

// File: bench/blp_ctrl_sva.sv
`timescale 1ns/1ns
module blp_ctrl_sva #(
    parameter int LEB_CYCLES = 3,
    parameter int TON_CYCLES = 250,
    parameter int TOFF_CYCLES = 200
) (
    input wire logic clock,
    input wire logic rst,
    input wire blp_pkg::blp_cmp_s cmp_in,
    input wire logic switch_on,
    input wire logic startup_source_on,
    input wire logic backup_regulator_on,
    input wire blp_pkg::blp_fault_s fault,
    input wire logic running
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    int on_reg, on_next, off_reg, off_next;
    always_comb begin
        on_next = switch_on ? on_reg + 1 : 0;
        off_next = (running && !switch_on) ? off_reg + 1 : 0;
    end
    always_ff @(posedge clock) begin
        on_reg <= rst ? 0 : on_next;
        off_reg <= rst ? 0 : off_next;
    end
    chk_ton_limit: assert property (on_reg <= TON_CYCLES + 1)
        else $error("on time too long");
    chk_toff_limit: assert property (off_reg <= TOFF_CYCLES + 1)
        else $error("off time too long");
    chk_blank_min: assert property ($fell(switch_on) && running |-> on_reg >= LEB_CYCLES)
        else $error("on stroke ended inside blanking");
    chk_fault_halt: assert property (fault != 0 && $past(fault) != 0 |-> !switch_on)
        else $error("switching while faulted");
    chk_source_off: assert property (startup_source_on |-> !running)
        else $error("start-up source on while running");
    chk_run_switch: assert property (switch_on |-> running)
        else $error("switch on while not running");
    chk_stop_halt: assert property (cmp_in.supply_stop_level [*8] |-> !switch_on)
        else $error("switching below stop level");
    chk_reg_follow: assert property (cmp_in.backup_regulator_on_level [*7] |-> backup_regulator_on)
        else $error("backup regulator not on");
    chk_reset_state: assert property (disable iff (1'b0) rst |=> !switch_on && startup_source_on && fault == 0)
        else $error("bad state after reset");
    cover property ($fell(switch_on) && running);
    cover property (fault.output_short_trip);
    cover property (fault.shorted_coil_trip);
endmodule

// File: bench/blp_coil_model.sv
`timescale 1ns/1ns
module blp_coil_model (
    input wire logic clock,
    input wire logic switch_on,
    input wire logic trip_en,
    input wire logic short_en,
    output logic sense_trip,
    output logic sense_short,
    output logic coil_zero,
    output logic valley
);
    int on_n = 0;
    int off_n = 0;
    always @(posedge clock) begin
        on_n <= switch_on ? on_n + 1 : 0;
        off_n <= switch_on ? 0 : off_n + 1;
    end
    // Sense resistor pulls the pin to 0 once the switch is off
    assign sense_trip = switch_on && trip_en && on_n >= 8;
    assign sense_short = switch_on && short_en && on_n >= 8;
    assign coil_zero = !switch_on && off_n >= 10;
    // Held six cycles so the input filter can accept it
    assign valley = coil_zero && off_n >= 14 && off_n < 20;
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam int TON = 60;
    localparam int TOFF = 50;
    logic clock = 0;
    logic rst = 1;
    logic st = 0, sp = 1, rl = 0, bk = 0, ota = 0, otr = 1, led = 0;
    logic trip = 1, vly = 1, sht = 0;
    logic m_trip, m_sht, m_zero, m_vly;
    logic switch_on, startup_source_on, backup_regulator_on, running;
    blp_pkg::blp_cmp_s cmp_in;
    blp_pkg::blp_fault_s fault;
    int n_fail = 0;
    int checks_done = 0;
    int t_on, t_off, k;
    logic [3:0] rows [4] = '{4'hc, 4'h9, 4'h6, 4'h3};
    always #50 clock = ~clock;
    assign cmp_in = '{st, sp, rl, bk, m_trip, m_sht, m_zero, m_vly, vly,
        ota, otr, led};
    blp_ctrl #(.LEB_CYCLES(3), .TON_CYCLES(TON), .TOFF_CYCLES(TOFF),
        .SC_CYCLES(500)) blp_ctrl_i (.clock(clock), .rst(rst),
        .cmp_in(cmp_in), .switch_on(switch_on),
        .startup_source_on(startup_source_on),
        .backup_regulator_on(backup_regulator_on), .fault(fault),
        .running(running));
    blp_coil_model blp_coil_model_i (.clock(clock), .switch_on(switch_on),
        .trip_en(trip), .short_en(sht), .sense_trip(m_trip),
        .sense_short(m_sht), .coil_zero(m_zero), .valley(m_vly));
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cycle_len(output int t_on, output int t_off);
        k = 0;
        while (!switch_on && k < 1000) begin @(negedge clock); k++; end
        t_on = 0;
        while (switch_on && t_on < 1000) begin @(negedge clock); t_on++; end
        t_off = 0;
        while (!switch_on && t_off < 1000) begin @(negedge clock); t_off++; end
    endtask
    task automatic power_cycle(input logic deep);
        {st, sp, rl} = {2'b01, deep};
        repeat (20) @(negedge clock);
        check({3'b0, startup_source_on}, 4'h1);
        {st, sp, rl, ota, otr, led, sht} = 7'b1000100;
        for (k = 0; k < 100 && !running; k++) @(negedge clock);
        check({3'b0, running}, 4'h1);
        check(fault, 4'h0);
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clock);
        rst = 0;
        repeat (10) @(negedge clock);
        check({switch_on, startup_source_on, running, 1'b0}, 4'h4);
        bk = 1;
        repeat (10) @(negedge clock);
        check({3'b0, backup_regulator_on}, 4'h1);
        bk = 0;
        repeat (10) @(negedge clock);
        check({3'b0, backup_regulator_on}, 4'h0);
        {st, sp} = 2'b10;
        for (int i = 0; i < 4; i++) begin
            {trip, vly} = rows[i][3:2];
            cycle_len(t_on, t_off);
            cycle_len(t_on, t_off);
            k = {t_on > TON - 3, t_off > TOFF - 3};
            check(k[3:0], {2'b0, rows[i][1:0]});
        end
        // Each on-time limit clears the short timer, so no trip here
        repeat (800) @(negedge clock);
        check(fault, 4'h0);
        trip = 1;
        for (k = 0; k < 1000 && fault == 0; k++) @(negedge clock);
        check(fault, 4'h4);
        repeat (200) @(negedge clock);
        check({2'b0, switch_on, running}, 4'h0);
        power_cycle(1);
        {trip, vly, sht} = 3'b011;
        for (k = 0; k < 200 && fault == 0; k++) @(negedge clock);
        check(fault, 4'h8);
        power_cycle(1);
        for (int j = 0; j < 2; j++) begin
            {ota, otr, led} = j ? 3'b011 : 3'b100;
            for (k = 0; k < 50 && fault == 0; k++) @(negedge clock);
            check(fault, j ? 4'h1 : 4'h2);
            power_cycle(0);
        end
        wrap_up();
    end
    initial begin
        #2000000;
        n_fail++;
        wrap_up();
    end
endmodule
bind blp_ctrl blp_ctrl_sva #(.LEB_CYCLES(LEB_CYCLES), .TON_CYCLES(TON_CYCLES),
    .TOFF_CYCLES(TOFF_CYCLES)) blp_ctrl_sva_i (.clock(clock), .rst(rst),
    .cmp_in(cmp_in), .switch_on(switch_on),
    .startup_source_on(startup_source_on),
    .backup_regulator_on(backup_regulator_on), .fault(fault),
    .running(running));
